// ### hdl/graphic_lcd_controller_core.v
// Core of a 40-row by 101-column graphic display controller: write-only
// command/data byte port, display memory, display modes, row scan, power-down.
// Assumes the serial slave front end delivers whole bytes as one-cycle strobes.
//
// Behaviour
// - One frame spans 3072 display clock ticks.
// - Power-on reset is synchronous and ends after 2 display clock ticks.
// - After power-on reset, power-down stops oscillator, bias; row and column outputs high.
// - Memory, pointer and control bits survive power-down entry and exit.
// - Commands and data still execute in power-down with external clock.
// - One 8-bit register holds each byte, command or data by its command flag.
// - Nothing written can be read back by the host.
// - Pointer advances by one after each stored data byte, per direction bit.
// - Memory is 5 line banks of 101 bytes, eight stacked pixels each.
// - Column value n always feeds column output n.
// - Two status bits select blank, normal, all-on or inverse display.
// - Rows scan continuously one at a time over 40 rows, 101 columns.
// - Host writes never corrupt or stall the row scan.
// - Slave address low bit is the static level of the select pin.
// - Command with top bit 0: enable, polarity, power-down, direction, line.
// - Mode 00 blank, 11 normal, 10 all on, 01 inverse.
// - Column values run 0 to 100; larger values are not programmed.
// - After power-on reset the block enters power-down with bit set.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_core_defs.vh"

module graphic_lcd_controller_core #(
   parameter [15:0] OSC_DIV     = `OSC_DIV_DEFAULT,
   parameter [15:0] EXT_TIMEOUT = `EXT_TIMEOUT_DEFAULT
) (
   input  wire         i_clk,
   input  wire         i_rst,
   input  wire         i_clock_input_pin,
   input  wire         i_address_select_pin,
   input  wire         i_xfer_start,
   input  wire         i_wr_valid,
   input  wire         i_wr_is_cmd,
   input  wire [7:0]   i_wr_data,
   output wire         o_wr_ready,
   output reg  [6:0]   o_slave_address,
   output reg  [39:0]  o_rows,
   output reg  [100:0] o_cols,
   output reg          o_frame_start,
   output wire         o_power_down,
   output wire [1:0]   o_display_mode,
   output wire         o_por_busy
);

   localparam NUM_ROWS  = `LCD_NUM_ROWS;
   localparam NUM_COLS  = `LCD_NUM_COLS;
   localparam MEM_WORDS = `LCD_MEM_WORDS;

   // Command phase: display control byte first, then column address byte
   localparam PH_CONTROL = 1'b0;
   localparam PH_ADDRESS = 1'b1;

   function [8:0] mem_index;
      input [2:0] line;
      input [6:0] col;
      begin
         mem_index = ({6'h00, line} * 9'h065) + {2'h0, col};
      end
   endfunction

   function [7:0] apply_mode;
      input [1:0] mode;
      input [7:0] pix;
      begin
         case (mode)
            `MODE_BLANK:   apply_mode = 8'h00;
            `MODE_NORMAL:  apply_mode = pix;
            `MODE_ALL_ON:  apply_mode = 8'hff;
            `MODE_INVERSE: apply_mode = ~pix;
            default:       apply_mode = 8'h00;
         endcase
      end
   endfunction

   function [39:0] row_onehot;
      input [5:0] row;
      begin
         row_onehot = 40'h00_0000_0001 << row;
      end
   endfunction

   // Control state
   reg        power_down_bit_r;
   reg        enable_r;
   reg        polarity_r;
   reg        vertical_r;
   reg        phase_r;
   reg [1:0]  por_cnt_r;
   reg        por_done_r;
   reg [7:0]  hold_r;
   reg        hold_valid_r;
   reg        hold_cmd_r;
   reg        sa_sync1_r;
   reg        sa_sync2_r;

   // Scan state
   reg [11:0] frame_cnt_r;
   reg [11:0] row_acc_r;
   reg [5:0]  row_r;
   reg [7:0]  display_memory [0:MEM_WORDS-1];

   wire       tick;
   wire       ext_active;
   wire [2:0] ptr_line;
   wire [6:0] ptr_col;

   assign o_power_down   = power_down_bit_r;
   assign o_display_mode = {enable_r, polarity_r};
   assign o_por_busy     = ~por_done_r;

   // Bytes need a live clock: the internal one stops in power-down
   assign o_wr_ready = por_done_r & (~power_down_bit_r | ext_active);

   // Oscillator runs through power-on reset, then only out of power-down
   wire osc_enable = ~por_done_r | ~power_down_bit_r;

   // Last reset tick: both the reset counter and the control bits act on it
   wire por_last = ~por_done_r & tick & (por_cnt_r == `LCD_POR_TICKS - 2'h1);

   clock_source #(
      .OSC_DIV     (OSC_DIV),
      .EXT_TIMEOUT (EXT_TIMEOUT)
   ) u_clock_source (
      .i_clk             (i_clk),
      .i_rst             (i_rst),
      .i_clock_input_pin (i_clock_input_pin),
      .i_osc_enable      (osc_enable),
      .o_tick            (tick),
      .o_ext_active      (ext_active)
   );

   // Power-on reset holds off commands until enough display clock ticks
   always @(posedge i_clk) begin
      if (i_rst) begin
         por_cnt_r  <= 2'h0;
         por_done_r <= 1'b0;
      end else if (!por_done_r && tick) begin
         if (por_last) begin
            por_done_r <= 1'b1;
         end
         por_cnt_r <= por_cnt_r + 2'h1;
      end
   end

   // Single holding register; the command flag and then the phase decide the byte's meaning
   // A byte offered while not ready is lost; the front end must not acknowledge it
   wire accept = i_wr_valid & o_wr_ready;

   always @(posedge i_clk) begin
      if (i_rst) begin
         hold_r       <= 8'h00;
         hold_valid_r <= 1'b0;
         hold_cmd_r   <= 1'b0;
      end else begin
         hold_valid_r <= accept;
         if (accept) begin
            hold_r     <= i_wr_data;
            hold_cmd_r <= i_wr_is_cmd;
         end
      end
   end

   // Bytes execute one cycle after capture, in the acknowledge slot
   wire exec_cmd   = hold_valid_r & hold_cmd_r & ~hold_r[`CMD_TOP_BIT];
   wire exec_ctrl  = exec_cmd & (phase_r == PH_CONTROL);
   wire exec_addr  = exec_cmd & (phase_r == PH_ADDRESS);
   wire exec_data  = hold_valid_r & ~hold_cmd_r;
   wire ptr_in_map = (ptr_line <= `LCD_MAX_LINE) && (ptr_col <= `LCD_MAX_COL);

   always @(posedge i_clk) begin
      if (i_rst) begin
         phase_r <= PH_CONTROL;
      end else if (i_xfer_start) begin
         phase_r <= PH_CONTROL;
      end else if (exec_cmd) begin
         phase_r <= ~phase_r;
      end
   end

   // Display control bits; power-down is only ever changed by command or reset
   always @(posedge i_clk) begin
      if (i_rst) begin
         power_down_bit_r <= 1'b1;
         enable_r         <= 1'b0;
         polarity_r       <= 1'b0;
         vertical_r       <= 1'b0;
      end else if (por_last) begin
         power_down_bit_r <= 1'b1;
      end else if (exec_ctrl) begin
         enable_r         <= hold_r[`CMD_ENABLE_BIT];
         polarity_r       <= hold_r[`CMD_POLARITY_BIT];
         power_down_bit_r <= hold_r[`CMD_PD_BIT];
         vertical_r       <= hold_r[`CMD_VERTICAL_BIT];
      end
   end

   write_pointer u_write_pointer (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_load_line (exec_ctrl),
      .i_line      (hold_r[`CMD_LINE_MSB:0]),
      .i_load_col  (exec_addr),
      .i_col       (hold_r[`CMD_COL_MSB:0]),
      .i_advance   (exec_data),
      .i_vertical  (vertical_r),
      .o_line      (ptr_line),
      .o_col       (ptr_col)
   );

   // Memory write port; the scan only reads, so writes never stall it.
   // Out-of-range pointer values drop the byte but still advance.
   wire       mem_wr_en   = exec_data & ptr_in_map;
   wire [8:0] mem_wr_addr = mem_index(ptr_line, ptr_col);

   always @(posedge i_clk) begin
      if (mem_wr_en) begin
         display_memory[mem_wr_addr] <= hold_r;
      end
   end

   // Row timing: 40 row steps spread evenly over one frame of ticks.
   // Scan counters are not reset by power-down so the frame resumes in step.
   // Row and frame counters start together, so each frame opens on row 0.
   wire [11:0] acc_sum = row_acc_r + `LCD_ROW_STEP;
   wire        row_step = (acc_sum >= `LCD_FRAME_TICKS);
   wire        frame_end = (frame_cnt_r == `LCD_FRAME_TICKS - 12'h001);

   always @(posedge i_clk) begin
      if (i_rst) begin
         frame_cnt_r   <= 12'h000;
         row_acc_r     <= 12'h000;
         row_r         <= 6'h00;
         o_frame_start <= 1'b0;
      end else begin
         o_frame_start <= tick & frame_end;
         if (tick) begin
            frame_cnt_r <= frame_end ? 12'h000 : frame_cnt_r + 12'h001;
            if (row_step) begin
               row_acc_r <= acc_sum - `LCD_FRAME_TICKS;
               row_r     <= (row_r == NUM_ROWS - 1) ? 6'h00 : row_r + 6'h01;
            end else begin
               row_acc_r <= acc_sum;
            end
         end
      end
   end

   // Column data for the active row: bank from row/8, bit from row mod 8
   wire [2:0]          scan_bank = row_r[5:3];
   wire [2:0]          scan_bit  = row_r[2:0];
   wire [NUM_COLS-1:0] col_pix;

   genvar c;
   generate
      for (c = 0; c < NUM_COLS; c = c + 1) begin : g_col
         localparam [6:0] COL_IDX = c;
         wire [7:0] shown = apply_mode(o_display_mode,
                            display_memory[mem_index(scan_bank, COL_IDX)]);
         assign col_pix[c] = shown[scan_bit];
      end
   endgenerate

   // Registered panel drive; power-down forces every output to the high level
   always @(posedge i_clk) begin
      if (i_rst) begin
         o_rows <= {NUM_ROWS{1'b1}};
         o_cols <= {NUM_COLS{1'b1}};
      end else if (power_down_bit_r) begin
         o_rows <= {NUM_ROWS{1'b1}};
         o_cols <= {NUM_COLS{1'b1}};
      end else begin
         o_rows <= row_onehot(row_r);
         o_cols <= col_pix;
      end
   end

   // Slave address low bit from a static strap, synchronised before use
   always @(posedge i_clk) begin
      if (i_rst) begin
         sa_sync1_r      <= 1'b0;
         sa_sync2_r      <= 1'b0;
         o_slave_address <= 7'h00;
      end else begin
         sa_sync1_r      <= i_address_select_pin;
         sa_sync2_r      <= sa_sync1_r;
         o_slave_address <= {`SLAVE_ADDR_HIGH, sa_sync2_r};
      end
   end

   // No read path exists: the holding register feeds only internal logic.

endmodule // graphic_lcd_controller_core
`default_nettype wire

// ### hdl/lcd_core_defs.vh
// Constants shared by the graphic display controller core files.
// Assumes it is included by bare name after `timescale in each design file.
`ifndef LCD_CORE_DEFS_VH
`define LCD_CORE_DEFS_VH

// Panel and memory geometry
`define LCD_NUM_ROWS        40
`define LCD_NUM_COLS        101
`define LCD_NUM_LINES       5
`define LCD_MAX_COL         7'h64
`define LCD_MAX_LINE        3'h4
`define LCD_MEM_WORDS       505

// Display clock ticks per frame and power-on reset length in ticks
`define LCD_FRAME_TICKS     12'hc00
`define LCD_ROW_STEP        12'h028
`define LCD_POR_TICKS       2'h2

// Command byte fields
`define CMD_TOP_BIT         7
`define CMD_ENABLE_BIT      6
`define CMD_POLARITY_BIT    5
`define CMD_PD_BIT          4
`define CMD_VERTICAL_BIT    3
`define CMD_LINE_MSB        2
`define CMD_COL_MSB         6

// Display modes as {enable, polarity}
`define MODE_BLANK          2'h0
`define MODE_INVERSE        2'h1
`define MODE_ALL_ON         2'h2
`define MODE_NORMAL         2'h3

// Upper six bits of the serial slave address; the lowest comes from a pin
`define SLAVE_ADDR_HIGH     6'h1e

// Internal oscillator divider and external clock watchdog defaults (cycles)
`define OSC_DIV_DEFAULT     16'h0040
`define EXT_TIMEOUT_DEFAULT 16'h0100

`endif

// ### hdl/write_pointer.v
// Auto-incrementing write pointer (line bank and column) into display memory.
// Assumes load and advance strobes are single-cycle pulses on i_clk.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_core_defs.vh"

module write_pointer (
   input  wire       i_clk,
   input  wire       i_rst,
   input  wire       i_load_line,
   input  wire [2:0] i_line,
   input  wire       i_load_col,
   input  wire [6:0] i_col,
   input  wire       i_advance,
   input  wire       i_vertical,
   output reg  [2:0] o_line,
   output reg  [6:0] o_col
);

   wire line_end = (o_line == `LCD_MAX_LINE);
   wire col_end  = (o_col == `LCD_MAX_COL);

   always @(posedge i_clk) begin
      if (i_rst) begin
         o_line <= 3'h0;
         o_col  <= 7'h00;
      end else begin
         if (i_load_line) begin
            o_line <= i_line;
         end
         if (i_load_col) begin
            o_col <= i_col;
         end
         if (i_advance) begin
            if (i_vertical) begin
               o_line <= line_end ? 3'h0 : o_line + 3'h1;
               if (line_end) begin
                  o_col <= col_end ? 7'h00 : o_col + 7'h01;
               end
            end else begin
               o_col <= col_end ? 7'h00 : o_col + 7'h01;
               if (col_end) begin
                  o_line <= line_end ? 3'h0 : o_line + 3'h1;
               end
            end
         end
      end
   end

endmodule // write_pointer
`default_nettype wire

// ### hdl/clock_source.v
// Display clock source: external clock pin sampled on i_clk, or an internal
// oscillator modelled as a divider, delivered as one-cycle tick enables.
// Assumes the pin is asynchronous to i_clk and much slower than it.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_core_defs.vh"

module clock_source #(
   parameter [15:0] OSC_DIV     = `OSC_DIV_DEFAULT,
   parameter [15:0] EXT_TIMEOUT = `EXT_TIMEOUT_DEFAULT
) (
   input  wire i_clk,
   input  wire i_rst,
   input  wire i_clock_input_pin,
   input  wire i_osc_enable,
   output reg  o_tick,
   output wire o_ext_active
);

   reg        sync1_r;
   reg        sync2_r;
   reg        pin_d_r;
   reg [15:0] idle_r;
   reg [15:0] div_r;

   // A pin tied high looks like an external clock that stopped high
   assign o_ext_active = (idle_r < EXT_TIMEOUT);

   always @(posedge i_clk) begin
      if (i_rst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         pin_d_r <= 1'b0;
         idle_r  <= EXT_TIMEOUT;
         div_r   <= 16'h0000;
         o_tick  <= 1'b0;
      end else begin
         sync1_r <= i_clock_input_pin;
         sync2_r <= sync1_r;
         pin_d_r <= sync2_r;
         if (sync2_r != pin_d_r) begin
            idle_r <= 16'h0000;
         end else if (idle_r < EXT_TIMEOUT) begin
            idle_r <= idle_r + 16'h0001;
         end
         // Oscillator stops when disabled; an external clock still counts
         if (!o_ext_active && sync2_r && i_osc_enable) begin
            div_r <= (div_r >= OSC_DIV - 16'h0001) ? 16'h0000 : div_r + 16'h0001;
         end else begin
            div_r <= 16'h0000;
         end
         if (o_ext_active) begin
            o_tick <= sync2_r & ~pin_d_r;
         end else begin
            o_tick <= sync2_r && i_osc_enable && (div_r >= OSC_DIV - 16'h0001);
         end
      end
   end

endmodule // clock_source
`default_nettype wire

// ### verification/lcd_core_checker.sv
// Concurrent checks on the ports of the display controller core.
// Assumes one clock i_clk with synchronous active-high reset i_rst.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_core_defs.vh"
module lcd_core_checker #(
   parameter [15:0] OSC_DIV     = `OSC_DIV_DEFAULT,
   parameter [15:0] EXT_TIMEOUT = `EXT_TIMEOUT_DEFAULT
) (
   input wire logic         i_clk,
   input wire logic         i_rst,
   input wire logic         i_address_select_pin,
   input wire logic         i_xfer_start,
   input wire logic         i_wr_valid,
   input wire logic         i_wr_is_cmd,
   input wire logic [7:0]   i_wr_data,
   input wire logic         o_wr_ready,
   input wire logic [6:0]   o_slave_address,
   input wire logic [39:0]  o_rows,
   input wire logic [100:0] o_cols,
   input wire logic         o_frame_start,
   input wire logic         o_power_down,
   input wire logic [1:0]   o_display_mode,
   input wire logic         o_por_busy
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Control byte must follow the start marker directly
   sequence s_ctrl;
      i_xfer_start ##1 (i_wr_valid && o_wr_ready && i_wr_is_cmd && !i_wr_data[7]);
   endsequence
   sequence s_pd_held;
      o_power_down [*3];
   endsequence
   a_mode_cmd: assert property (s_ctrl |-> ##2 (o_display_mode == $past(i_wr_data[6:5], 2))
      && (o_power_down == $past(i_wr_data[4], 2))) else $error("control byte not applied");
   a_pd_outputs: assert property (s_pd_held |-> (&o_rows) && (&o_cols))
      else $error("outputs not high in power-down");
   a_reset_state: assert property (disable iff (1'b0) i_rst |=> o_power_down && o_por_busy)
      else $error("reset state wrong");
   a_por_blocks: assert property (o_por_busy |-> !o_wr_ready)
      else $error("ready during power-on reset");
   a_pd_after_por: assert property ($fell(o_por_busy) |-> o_power_down)
      else $error("not in power-down after reset");
   a_ready_on: assert property (!o_por_busy && !o_power_down |-> o_wr_ready)
      else $error("port not ready");
   a_slave_addr: assert property (!o_por_busy |->
      o_slave_address == {`SLAVE_ADDR_HIGH, $past(i_address_select_pin, 3)})
      else $error("slave address wrong");
   a_frame_pulse: assert property (o_frame_start |=> !o_frame_start)
      else $error("frame pulse too long");
endmodule // lcd_core_checker
bind graphic_lcd_controller_core lcd_core_checker #(.OSC_DIV(OSC_DIV), .EXT_TIMEOUT(EXT_TIMEOUT))
   u_lcd_core_checker (.i_clk(i_clk), .i_rst(i_rst), .i_address_select_pin(i_address_select_pin),
   .i_xfer_start(i_xfer_start), .i_wr_valid(i_wr_valid), .i_wr_is_cmd(i_wr_is_cmd),
   .i_wr_data(i_wr_data), .o_wr_ready(o_wr_ready), .o_slave_address(o_slave_address),
   .o_rows(o_rows), .o_cols(o_cols), .o_frame_start(o_frame_start),
   .o_power_down(o_power_down), .o_display_mode(o_display_mode), .o_por_busy(o_por_busy));
`default_nettype wire

// ### verification/board_clock_model.sv
// Board-side model: drives the clock input pin with an external display clock.
// Assumes the bench clock i_clk; the pin toggles every HALF cycles of it.
`timescale 1ns/1ps
`default_nettype none
module board_clock_model #(
   parameter integer HALF = 2
) (
   input  wire logic i_clk,
   input  wire logic i_hold_high,
   output var  logic o_clock_input_pin
);
   integer count_r = 0;
   initial o_clock_input_pin = 1'b0;
   // Toggles unless strapped high for the internal oscillator, so no DC level
   always @(posedge i_clk) begin
      if (i_hold_high) begin
         o_clock_input_pin <= 1'b1;
      end else if (count_r == HALF - 1) begin
         count_r <= 0;
         o_clock_input_pin <= ~o_clock_input_pin;
      end else begin
         count_r <= count_r + 1;
      end
   end
endmodule // board_clock_model
`default_nettype wire

// ### verification/graphic_lcd_controller_core_bench.sv
// Self-checking bench for the display controller core.
// Assumes the board model clocks the clock pin, strapping it high only at the end.
`timescale 1ns/1ps
`default_nettype none
module graphic_lcd_controller_core_bench;
   localparam integer HALF  = 1;
   localparam integer FRAME = 3072 * 2 * HALF;
   logic         i_clk = 1'b0;
   logic         i_rst = 1'b1;
   logic         i_xfer_start = 1'b0;
   logic         i_wr_valid = 1'b0;
   logic         i_wr_is_cmd = 1'b0;
   logic [7:0]   i_wr_data = 8'h00;
   logic         clk_pin;
   logic         addr_pin = 1'b1;
   logic         pin_high = 1'b0;
   wire          o_wr_ready;
   wire  [6:0]   o_slave_address;
   wire  [39:0]  o_rows;
   wire  [100:0] o_cols;
   wire          o_frame_start;
   wire          o_power_down;
   wire  [1:0]   o_display_mode;
   wire          o_por_busy;
   integer       mismatches = 0;
   integer       samples_checked = 0;
   integer       i;
   always #2.5 i_clk = ~i_clk;
   board_clock_model #(.HALF(HALF)) u_board_clock_model (.i_clk(i_clk), .i_hold_high(pin_high),
      .o_clock_input_pin(clk_pin));
   graphic_lcd_controller_core #(.OSC_DIV(16'h0004), .EXT_TIMEOUT(16'h0010))
      u_graphic_lcd_controller_core (.i_clk(i_clk), .i_rst(i_rst), .i_clock_input_pin(clk_pin),
      .i_address_select_pin(addr_pin), .i_xfer_start(i_xfer_start), .i_wr_valid(i_wr_valid),
      .i_wr_is_cmd(i_wr_is_cmd), .i_wr_data(i_wr_data), .o_wr_ready(o_wr_ready),
      .o_slave_address(o_slave_address), .o_rows(o_rows), .o_cols(o_cols),
      .o_frame_start(o_frame_start), .o_power_down(o_power_down),
      .o_display_mode(o_display_mode), .o_por_busy(o_por_busy));
   task automatic check(input string name, input logic [100:0] seen, input logic [100:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic put(input logic c, input logic [7:0] d);
      i_wr_valid <= 1'b1;
      i_wr_is_cmd <= c;
      i_wr_data <= d;
      @(posedge i_clk);
   endtask
   // Start marker, then control byte and address byte back to back
   task automatic ctl(input logic [7:0] c, input logic [7:0] col);
      i_wr_valid <= 1'b0;
      i_xfer_start <= 1'b1;
      @(posedge i_clk);
      i_xfer_start <= 1'b0;
      put(1'b1, c);
      put(1'b1, col);
   endtask
   task automatic idle;
      i_wr_valid <= 1'b0;
      repeat (3) @(posedge i_clk);
      #1;
   endtask
   // Waits for the scan to reach a row, then looks at one column
   task automatic pixel(input integer row, input integer col, input logic exp);
      integer n;
      n = 0;
      while (o_rows !== (40'h1 << row) && n < FRAME + 100) begin
         @(posedge i_clk);
         #1;
         n = n + 1;
      end
      check("row", o_rows, 40'h1 << row);
      check("pixel", o_cols[col], exp);
   endtask
   task automatic t_reset;
      integer n;
      check("pd", o_power_down, 1'b1);
      check("rows", o_rows, {40{1'b1}});
      check("busy", o_por_busy, 1'b1);
      check("ready", o_wr_ready, 1'b0);
      n = 0;
      while (o_wr_ready !== 1'b1 && n < 200) begin
         @(posedge i_clk);
         #1;
         n = n + 1;
      end
      check("ready", o_wr_ready, 1'b1);
      check("pd", o_power_down, 1'b1);
      check("addr", o_slave_address, 7'h3d);
      addr_pin <= 1'b0;
      repeat (4) @(posedge i_clk);
      #1;
      check("addr", o_slave_address, 7'h3c);
   endtask
   task automatic t_frame;
      integer n;
      n = 0;
      while (o_frame_start !== 1'b1 && n < FRAME + 100) begin
         @(posedge i_clk);
         #1;
         n = n + 1;
      end
      n = 0;
      do begin
         @(posedge i_clk);
         #1;
         n = n + 1;
      end while (o_frame_start !== 1'b1 && n < FRAME + 100);
      check("frame", n, FRAME);
   endtask
   task automatic t_pointer;
      ctl(8'h60, 8'h00);
      for (i = 0; i < 505; i = i + 1) put(1'b0, 8'h00);
      ctl(8'h60, 8'h64);
      put(1'b0, 8'h01);
      put(1'b0, 8'h04);
      ctl(8'h6b, 8'h07);
      put(1'b0, 8'h80);
      put(1'b0, 8'h01);
      put(1'b0, 8'h01);
      idle();
      check("pd", o_power_down, 1'b0);
      pixel(0, 100, 1'b1);
      pixel(0, 8, 1'b1);
      pixel(0, 0, 1'b0);
      pixel(10, 0, 1'b1);
      pixel(31, 7, 1'b1);
      pixel(32, 7, 1'b1);
   endtask
   task automatic t_modes;
      logic [1:0] m;
      for (i = 0; i < 4; i = i + 1) begin
         m = i[1:0];
         ctl({1'b0, m, 5'h00}, 8'h64);
         idle();
         check("mode", o_display_mode, m);
         pixel(0, 100, m[1]);
         pixel(0, 99, m[1] ^ m[0]);
      end
   endtask
   // Writes made in power-down must land and survive the exit
   task automatic t_power_down;
      ctl(8'h70, 8'h63);
      put(1'b0, 8'h01);
      idle();
      check("pd", o_power_down, 1'b1);
      check("cols", o_cols, {101{1'b1}});
      ctl(8'h60, 8'h00);
      idle();
      pixel(0, 99, 1'b1);
      pixel(0, 100, 1'b1);
   endtask
   // Pin strapped high: the internal oscillator must scan, then the port must drop ready in power-down
   task automatic t_internal_osc;
      integer      n;
      logic [39:0] r;
      pin_high <= 1'b1;
      repeat (40) @(posedge i_clk);
      #1;
      r = o_rows;
      n = 0;
      while (o_rows === r && n < 2000) begin
         @(posedge i_clk);
         #1;
         n = n + 1;
      end
      check("osc scan", n < 2000, 1'b1);
      ctl(8'h70, 8'h00);
      idle();
      check("pd", o_power_down, 1'b1);
      check("ready", o_wr_ready, 1'b0);
   endtask
   initial begin
      #(FRAME * 60); // About twelve frames of 5 ns cycles
      mismatches = mismatches + 1;
      complete_run();
   end
   initial begin
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      #1;
      t_reset();
      t_frame();
      t_pointer();
      t_modes();
      t_power_down();
      t_internal_osc();
      complete_run();
   end
endmodule // graphic_lcd_controller_core_bench
`default_nettype wire
